// *** test/test_dcir_regs.sv ***
// Self-checking bench of the DMA completion interrupt registers
`timescale 1ns/1ns
`include "dcir_defines.svh"
`default_nettype none
module test_dcir_regs;
  logic        mclk;
  logic        nrst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  tx_done;
  logic [3:0]  rx_done;
  logic        tx_engine_on;
  logic        rx_engine_on;
  logic        tx_irq;
  logic        rx_irq;
  logic        irq;
  int          fail_count;
  int          check_count;

  dcir_regs DUT (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_done(tx_done), .rx_done(rx_done),
    .tx_engine_on(tx_engine_on), .rx_engine_on(rx_engine_on), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Single AHB-Lite transfer, entered and left just after a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= dcir_pkg::DCIR_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= dcir_pkg::DCIR_HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    xfer(1'b1, a, d, rd);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    xfer(1'b0, a, 32'h0, rd);
    check(rd, exp);
  endtask

  // Port levels: tx_on, rx_on, tx_irq, rx_irq, irq
  task automatic pins_chk(input logic [4:0] exp);
    @(negedge mclk);
    check({27'h0, tx_engine_on, rx_engine_on, tx_irq, rx_irq, irq}, {27'h0, exp});
    @(posedge mclk);
  endtask

  task automatic pulse(input logic [3:0] t, input logic [3:0] r);
    tx_done <= t;
    rx_done <= r;
    @(posedge mclk);
    tx_done <= 4'h0;
    rx_done <= 4'h0;
    @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and unmapped place
  task automatic t_reset();
    for (int a = 0; a <= 'h30; a += 4) begin
      rd_chk(a[11:0], 32'h0); // Reset zero
    end
    rd_chk(12'h100, 32'h0);
    pins_chk(5'h00); // Outputs idle
  endtask

  task automatic t_control();
    wr(`DCIR_TX_CONTROL, 32'h1);
    pins_chk(5'h10); // Tx gate on
    rd_chk(`DCIR_TX_CONTROL, 32'h1); // Tx readback
    wr(`DCIR_RX_CONTROL, 32'hffffffff);
    rd_chk(`DCIR_RX_CONTROL, 32'h1); // Rx readback
    pins_chk(5'h18); // Both on
    wr(`DCIR_TX_CONTROL, 32'h0);
    wr(`DCIR_RX_CONTROL, 32'h0);
    pins_chk(5'h00); // Both off
  endtask

  task automatic t_enables();
    logic [11:0] s[2];
    logic [11:0] c[2];
    s = '{`DCIR_TX_EN_SET, `DCIR_RX_EN_SET};
    c = '{`DCIR_TX_EN_CLEAR, `DCIR_RX_EN_CLEAR};
    for (int i = 0; i < 2; i++) begin
      wr(s[i], 32'hfffffff5);
      rd_chk(s[i], 32'h5); // Set bits
      wr(s[i], 32'ha);
      rd_chk(c[i], 32'hf); // Rest set, read via clear
      wr(c[i], 32'h3);
      rd_chk(s[i], 32'hc); // Clear bits
      wr(c[i], 32'h0);
      rd_chk(s[i], 32'hc); // Zeros
      wr(c[i], 32'hc);
      rd_chk(s[i], 32'h0); // All clear
    end
  endtask

  task automatic t_events();
    wr(`DCIR_TX_EN_SET, 32'h4);
    wr(`DCIR_RX_EN_SET, 32'h1);
    wr(`DCIR_IRQ_MASK, 32'h3);
    pulse(4'hf, 4'h9);
    rd_chk(`DCIR_TX_RAW, 32'hf); // Tx raw
    rd_chk(`DCIR_RX_RAW, 32'h9); // Rx raw
    rd_chk(`DCIR_TX_MASKED, 32'h4); // Tx masked
    rd_chk(`DCIR_RX_MASKED, 32'h1); // Rx masked
    rd_chk(`DCIR_IRQ_STATUS, 32'h3);
    pins_chk(5'h07); // Requests up
    wr(`DCIR_RX_EN_CLEAR, 32'h1);
    rd_chk(`DCIR_RX_MASKED, 32'h0); // Rx masked off
    wr(`DCIR_IRQ_STATUS, 32'h3);
    pins_chk(5'h04); // Rx request gone
    wr(`DCIR_RAW_CLEAR, 32'hff);
    rd_chk(`DCIR_TX_RAW, 32'h0); // Raw cleared
    pins_chk(5'h00); // Tx request gone
    wr(`DCIR_IRQ_MASK, 32'h0);
    pulse(4'h4, 4'h0);
    rd_chk(`DCIR_IRQ_STATUS, 32'h1);
    pins_chk(5'h04); // Masked event
    wr(`DCIR_IRQ_MASK, 32'h1);
    pins_chk(5'h05); // Unmasked event
  endtask

  // Mid-run reset clears gates, flags, enables and requests
  task automatic t_midreset();
    wr(`DCIR_RX_CONTROL, 32'h1);
    pins_chk(5'h0d); // Rx gate with requests
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    pins_chk(5'h00); // Outputs idle again
    rd_chk(`DCIR_TX_RAW, 32'h0); // Raw reset
    rd_chk(`DCIR_TX_EN_SET, 32'h0); // Enables reset
    rd_chk(`DCIR_IRQ_MASK, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    fail_count  = 0;
    check_count = 0;
    nrst    = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    tx_done = 4'h0;
    rx_done = 4'h0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_control();
    t_enables();
    t_events();
    t_midreset();
    report_and_stop();
  end

  // Watchdog well beyond the 150 or so cycles of the run
  initial begin
    #50000;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** verilog/dcir_defines.svh ***
// Register offsets, field positions and reset values of the DMA completion interrupt block
`ifndef DCIR_DEFINES_SVH
`define DCIR_DEFINES_SVH

`define DCIR_TX_CONTROL      12'h000
`define DCIR_TX_MASKED       12'h004
`define DCIR_TX_RAW          12'h008
`define DCIR_TX_EN_SET       12'h00c
`define DCIR_TX_EN_CLEAR     12'h010
`define DCIR_RX_CONTROL      12'h014
`define DCIR_RX_MASKED       12'h018
`define DCIR_RX_RAW          12'h01c
`define DCIR_RX_EN_SET       12'h020
`define DCIR_RX_EN_CLEAR     12'h024
`define DCIR_IRQ_STATUS      12'h028
`define DCIR_IRQ_MASK        12'h02c
`define DCIR_RAW_CLEAR       12'h030

`define DCIR_ENGINE_ON_BIT   0
`define DCIR_EV_TX_BIT       0
`define DCIR_EV_RX_BIT       1
`define DCIR_RAW_CLR_RX_LSB  4
`define DCIR_CHANNELS        4
`define DCIR_ADDR_W          12
`define DCIR_ENABLE_RESET    4'h0
`define DCIR_MASK_RESET      2'h0

`endif

// *** verilog/dcir_pkg.sv ***
// Types of the DMA completion interrupt block
`default_nettype none
package dcir_pkg;
  typedef enum logic [1:0] {
    DCIR_HTRANS_IDLE   = 2'h0,
    DCIR_HTRANS_BUSY   = 2'h1,
    DCIR_HTRANS_NONSEQ = 2'h2,
    DCIR_HTRANS_SEQ    = 2'h3
  } dcir_htrans_t;
endpackage
`default_nettype wire

// *** verilog/dcir_regs.sv ***
// DMA completion status, enables and interrupts behind an AHB-Lite slave
//
// Overview of operation
// RULE_01: Tx clear write ones clear enables
// RULE_02: Rx control bit 0 gates engine
// RULE_03: Rx masked equals raw AND enables
// RULE_04: Rx raw holds per-channel done flags
// RULE_05: Rx set write ones set enables
// RULE_06: Rx clear write ones clear enables
// RULE_07: Rx enable bit pairs same channel
// RULE_08: Tx control bit 0 gates engine
// RULE_09: Tx raw holds per-channel done flags
// RULE_10: Tx masked equals raw AND enables
// RULE_11: Tx set write ones set enables
// RULE_12: Request raised while any masked bit
`timescale 1ns/1ns
`include "dcir_defines.svh"
`default_nettype none
module dcir_regs #(
  parameter int CH = `DCIR_CHANNELS
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          nrst,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  // Completion pulses from the DMA engines
  input  wire logic [CH-1:0] tx_done,
  input  wire logic [CH-1:0] rx_done,
  // Engine gates and requests
  output logic               tx_engine_on,
  output logic               rx_engine_on,
  output logic               tx_irq,
  output logic               rx_irq,
  output logic               irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture
  logic                     wr_pend;
  logic                     rd_pend;
  logic [`DCIR_ADDR_W-1:0]  addr_q;
  logic                     next_wr_pend;
  logic                     next_rd_pend;
  logic [`DCIR_ADDR_W-1:0]  next_addr_q;
  logic                     take;

  always_comb begin
    take         = hsel && hready && (htrans == 2'(dcir_pkg::DCIR_HTRANS_NONSEQ)
                   || htrans == 2'(dcir_pkg::DCIR_HTRANS_SEQ));
    next_wr_pend = take && hwrite;
    next_rd_pend = take && !hwrite;
    next_addr_q  = take ? haddr[`DCIR_ADDR_W-1:0] : addr_q;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= '0;
    end else begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      addr_q  <= next_addr_q;
    end
  end

  function automatic logic hit(input logic [`DCIR_ADDR_W-1:0] a,
                               input logic [`DCIR_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Status, enables and controls
  logic [CH-1:0] tx_raw;
  logic [CH-1:0] rx_raw;
  logic [CH-1:0] tx_en;
  logic [CH-1:0] rx_en;
  logic [1:0]    ev_stat;
  logic [1:0]    ev_mask;
  logic [CH-1:0] next_tx_raw;
  logic [CH-1:0] next_rx_raw;
  logic [CH-1:0] next_tx_en;
  logic [CH-1:0] next_rx_en;
  logic [1:0]    next_ev_stat;
  logic [1:0]    next_ev_mask;
  logic          next_tx_on;
  logic          next_rx_on;
  logic          next_tx_irq;
  logic          next_rx_irq;
  logic          next_irq;
  logic [CH-1:0] tx_masked;
  logic [CH-1:0] rx_masked;
  logic [CH-1:0] wd;
  logic [1:0]    new_ev;

  always_comb begin
    wd          = hwdata[CH-1:0];
    next_tx_raw = tx_raw;
    next_rx_raw = rx_raw;
    next_tx_en  = tx_en;
    next_rx_en  = rx_en;
    next_ev_mask = ev_mask;
    next_tx_on  = tx_engine_on;
    next_rx_on  = rx_engine_on;
    if (wr_pend) begin
      // RULE_08: tx engine gate
      if (hit(addr_q, `DCIR_TX_CONTROL))
        next_tx_on = hwdata[`DCIR_ENGINE_ON_BIT];
      // RULE_02: rx engine gate
      if (hit(addr_q, `DCIR_RX_CONTROL))
        next_rx_on = hwdata[`DCIR_ENGINE_ON_BIT];
      // RULE_11: tx write-one set
      if (hit(addr_q, `DCIR_TX_EN_SET))
        next_tx_en = tx_en | wd;
      // RULE_01: tx write-one clear
      if (hit(addr_q, `DCIR_TX_EN_CLEAR))
        next_tx_en = tx_en & ~wd;
      // RULE_05: rx write-one set
      if (hit(addr_q, `DCIR_RX_EN_SET))
        next_rx_en = rx_en | wd;
      // RULE_06: rx write-one clear
      if (hit(addr_q, `DCIR_RX_EN_CLEAR))
        next_rx_en = rx_en & ~wd;
      if (hit(addr_q, `DCIR_IRQ_MASK))
        next_ev_mask = hwdata[1:0];
      if (hit(addr_q, `DCIR_RAW_CLEAR)) begin
        next_tx_raw = tx_raw & ~wd;
        next_rx_raw = rx_raw & ~hwdata[`DCIR_RAW_CLR_RX_LSB +: CH];
      end
    end
    // RULE_09: tx done sets flag, set wins
    next_tx_raw = next_tx_raw | tx_done;
    // RULE_04: rx done sets flag, set wins
    next_rx_raw = next_rx_raw | rx_done;
    // RULE_10: tx masked view
    tx_masked   = tx_raw & tx_en;
    // RULE_03: rx masked view, same channel
    // RULE_07: enable pairs with its channel
    rx_masked   = rx_raw & rx_en;
    new_ev      = {|(rx_done & rx_en), |(tx_done & tx_en)};
    // Event set wins over a clear in the same cycle
    next_ev_stat = ev_stat;
    if (wr_pend && hit(addr_q, `DCIR_IRQ_STATUS))
      next_ev_stat = ev_stat & ~hwdata[1:0];
    next_ev_stat = next_ev_stat | new_ev;
    // RULE_12: requests follow masked status
    next_tx_irq = |(next_tx_raw & next_tx_en);
    next_rx_irq = |(next_rx_raw & next_rx_en);
    next_irq    = |(next_ev_stat & next_ev_mask);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_raw       <= '0;
      rx_raw       <= '0;
      tx_en        <= CH'(`DCIR_ENABLE_RESET);
      rx_en        <= CH'(`DCIR_ENABLE_RESET);
      ev_stat      <= 2'h0;
      ev_mask      <= `DCIR_MASK_RESET;
      tx_engine_on <= 1'b0;
      rx_engine_on <= 1'b0;
      tx_irq       <= 1'b0;
      rx_irq       <= 1'b0;
      irq          <= 1'b0;
    end else begin
      tx_raw       <= next_tx_raw;
      rx_raw       <= next_rx_raw;
      tx_en        <= next_tx_en;
      rx_en        <= next_rx_en;
      ev_stat      <= next_ev_stat;
      ev_mask      <= next_ev_mask;
      tx_engine_on <= next_tx_on;
      rx_engine_on <= next_rx_on;
      tx_irq       <= next_tx_irq;
      rx_irq       <= next_rx_irq;
      irq          <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered for the data phase
  logic [31:0] next_hrdata;
  // Next-state view, so a read right behind a write sees it

  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (take && !hwrite) begin
      case (haddr[`DCIR_ADDR_W-1:0])
        `DCIR_TX_CONTROL:  next_hrdata = {31'h0, next_tx_on};
        `DCIR_RX_CONTROL:  next_hrdata = {31'h0, next_rx_on};
        `DCIR_TX_MASKED:   next_hrdata = 32'(next_tx_raw & next_tx_en);
        `DCIR_RX_MASKED:   next_hrdata = 32'(next_rx_raw & next_rx_en);
        `DCIR_TX_RAW:      next_hrdata = 32'(next_tx_raw);
        `DCIR_RX_RAW:      next_hrdata = 32'(next_rx_raw);
        `DCIR_TX_EN_SET:   next_hrdata = 32'(next_tx_en);
        `DCIR_TX_EN_CLEAR: next_hrdata = 32'(next_tx_en);
        `DCIR_RX_EN_SET:   next_hrdata = 32'(next_rx_en);
        `DCIR_RX_EN_CLEAR: next_hrdata = 32'(next_rx_en);
        `DCIR_IRQ_STATUS:  next_hrdata = {30'h0, next_ev_stat};
        `DCIR_IRQ_MASK:    next_hrdata = {30'h0, next_ev_mask};
        default:           next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_tx_clear_en: assert property ( // RULE_01
    wr_pend && hit(addr_q, `DCIR_TX_EN_CLEAR) |=> ((tx_en & $past(wd)) == '0))
    else $error("tx enable not cleared");
  a_rx_engine_gate: assert property ( // RULE_02
    wr_pend && hit(addr_q, `DCIR_RX_CONTROL) |=> rx_engine_on == $past(hwdata[0]))
    else $error("rx engine gate wrong");
  a_rx_masked_read: assert property ( // RULE_03
    take && !hwrite && haddr[`DCIR_ADDR_W-1:0] == `DCIR_RX_MASKED
    |=> hrdata == 32'(rx_raw & rx_en))
    else $error("rx masked read wrong");
  a_rx_raw_set: assert property ( // RULE_04
    |rx_done |=> (rx_raw & $past(rx_done)) == $past(rx_done))
    else $error("rx done flag lost");
  a_rx_set_en: assert property ( // RULE_05
    wr_pend && hit(addr_q, `DCIR_RX_EN_SET) |=> ((rx_en & $past(wd)) == $past(wd)))
    else $error("rx enable not set");
  a_rx_clear_en: assert property ( // RULE_06
    wr_pend && hit(addr_q, `DCIR_RX_EN_CLEAR) |=> ((rx_en & $past(wd)) == '0))
    else $error("rx enable not cleared");
  a_rx_en_hold: assert property ( // RULE_07
    !(wr_pend && (hit(addr_q, `DCIR_RX_EN_SET) || hit(addr_q, `DCIR_RX_EN_CLEAR)))
    |=> $stable(rx_en))
    else $error("rx enable changed");
  a_tx_engine_gate: assert property ( // RULE_08
    wr_pend && hit(addr_q, `DCIR_TX_CONTROL) |=> tx_engine_on == $past(hwdata[0]))
    else $error("tx engine gate wrong");
  a_tx_raw_set: assert property ( // RULE_09
    |tx_done |=> (tx_raw & $past(tx_done)) == $past(tx_done))
    else $error("tx done flag lost");
  a_tx_irq_level: assert property ( // RULE_12
    ##1 (tx_irq == |tx_masked) && (rx_irq == |rx_masked))
    else $error("request level wrong");
  a_tx_set_en: assert property ( // RULE_11
    wr_pend && hit(addr_q, `DCIR_TX_EN_SET) |=> ((tx_en & $past(wd)) == $past(wd)))
    else $error("tx enable not set");
  a_tx_masked_read: assert property ( // RULE_10
    take && !hwrite && haddr[`DCIR_ADDR_W-1:0] == `DCIR_TX_MASKED
    |=> hrdata == 32'(tx_raw & tx_en))
    else $error("tx masked read wrong");

  // Enables and done flags move only through their own writes and pulses; event request follows status
  a_tx_en_hold: assert property ( // RULE_11
    !(wr_pend && (hit(addr_q, `DCIR_TX_EN_SET) || hit(addr_q, `DCIR_TX_EN_CLEAR)))
    |=> $stable(tx_en))
    else $error("tx enable changed");
  a_tx_clear_keep: assert property ( // RULE_01
    wr_pend && hit(addr_q, `DCIR_TX_EN_CLEAR) |=> tx_en == ($past(tx_en) & ~$past(wd)))
    else $error("tx enable clear wrong");
  a_rx_clear_keep: assert property ( // RULE_06
    wr_pend && hit(addr_q, `DCIR_RX_EN_CLEAR) |=> rx_en == ($past(rx_en) & ~$past(wd)))
    else $error("rx enable clear wrong");
  a_rx_set_keep: assert property ( // RULE_05
    wr_pend && hit(addr_q, `DCIR_RX_EN_SET) |=> rx_en == ($past(rx_en) | $past(wd)))
    else $error("rx enable set wrong");
  a_tx_raw_hold: assert property ( // RULE_09
    !(wr_pend && hit(addr_q, `DCIR_RAW_CLEAR)) && tx_done == '0 |=> $stable(tx_raw))
    else $error("tx done flag moved");
  a_rx_raw_hold: assert property ( // RULE_04
    !(wr_pend && hit(addr_q, `DCIR_RAW_CLEAR)) && rx_done == '0 |=> $stable(rx_raw))
    else $error("rx done flag moved");
  a_event_irq: assert property ( // RULE_12
    ##1 irq == |(ev_stat & ev_mask))
    else $error("event request wrong");

  c_tx_irq: cover property (|(tx_done & tx_en) ##2 tx_irq);
  c_rx_irq: cover property (|(rx_done & rx_en) ##2 rx_irq);
  c_irq_out: cover property (!irq ##1 irq);
  c_clear_write: cover property (wr_pend && hit(addr_q, `DCIR_RX_EN_CLEAR));
  c_raw_clear: cover property (wr_pend && hit(addr_q, `DCIR_RAW_CLEAR));

endmodule
`default_nettype wire
